// *** src/capcomp_reg.sv ***
`timescale 1ns/1ps
module capcomp_reg
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // software write
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // capture control
    input wire logic capture_mode,
    input wire logic count_en,
    input wire logic capture_now,
    input wire logic [15:0] count_val,
    // stored value
    output logic [15:0] value
);
    logic [15:0] value_r;
    logic [15:0] value_nxt;

    // capture registers hold nothing while the timer is stopped
    assign value_nxt = (capture_mode && !count_en) ? 16'h0000 :
                       (capture_mode && capture_now) ? count_val :
                       (!capture_mode && wr_en) ? wr_data : value_r;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            value_r <= 16'h0000;
        else
            value_r <= value_nxt;
    end

    assign value = value_r;
endmodule // capcomp_reg

// *** src/edge_detect.sv ***
`timescale 1ns/1ps
module edge_detect
    import timer_opt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // pin and selection
    input wire logic pin_in,
    input wire timer_opt_pkg::edge_sel_t edge_sel,
    // detected edge
    output logic edge_hit
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    wire rise_w = sync2_r & ~prev_r;
    wire fall_w = ~sync2_r & prev_r;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign edge_hit = (edge_sel == EDGE_RISE) ? rise_w :
                      (edge_sel == EDGE_FALL) ? fall_w :
                      (edge_sel == EDGE_BOTH) ? (rise_w | fall_w) : 1'b0;
endmodule // edge_detect

// *** src/timer_opt_params.svh ***
`ifndef TIMER_OPT_PARAMS_SVH
`define TIMER_OPT_PARAMS_SVH

// register offsets (byte addresses)
`define ADDR_OPTION 8'h00
`define ADDR_EDGE_SEL 8'h04
`define ADDR_COUNT 8'h08
`define ADDR_CTRL 8'h0c
`define ADDR_CCR0 8'h10
`define ADDR_CCR1 8'h14
`define ADDR_IRQ_STATUS 8'h18
`define ADDR_IRQ_MASK 8'h1c
`define ADDR_BIT_CLR 8'h20

// option register fields
`define OPT_OVF_BIT 0
`define OPT_CCS0_BIT 4
`define OPT_CCS1_BIT 5
`define OPT_RESET 8'h00
// control register fields
`define CTRL_CE_BIT 7
`define CTRL_MODE_LSB 0
`define CTRL_RESET 8'h00
// edge select field
`define EDGE_LSB 0
`define EDGE_RESET 8'h00
// irq status bits
`define IRQ_OVF_BIT 0
`define IRQ_CC0_BIT 1
`define IRQ_CC1_BIT 2
`define IRQ_RESET 8'h00
`define CNT_TOP 16'hffff
`define CNT_ZERO 16'h0000
`endif

// *** src/timer_opt_pkg.sv ***
package timer_opt_pkg;
    typedef enum logic [2:0] {
        MODE_INTERVAL = 3'h0,
        MODE_EXT_TRIG = 3'h1,
        MODE_PULSE_OUT = 3'h2,
        MODE_FREE_RUN = 3'h5,
        MODE_PULSE_WIDTH = 3'h6
    } timer_mode_t;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;
    typedef enum {
        PULSE_IDLE,
        PULSE_RUN
    } pulse_state_t;
endpackage

// *** src/timer_option_unit.sv ***
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "timer_opt_params.svh"
module timer_option_unit
    import timer_opt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // external pins
    input wire logic ext_trigger_pin,
    input wire logic capture_pin,
    output logic pulse_out,
    // interrupts
    output logic overflow_irq,
    output logic irq
);
    import timer_opt_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic ccs0_r;
    logic ccs1_r;
    logic overflow_flag_r;
    logic overflow_flag_nxt;
    logic [1:0] edge_sel_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [2:0] irq_status_r;
    logic [2:0] irq_status_nxt;
    logic [2:0] irq_mask_r;
    logic [15:0] rdata_r;
    logic pulse_r;
    logic ovf_irq_r;
    pulse_state_t pstate_r;
    pulse_state_t pstate_nxt;
    logic [15:0] ccr0_val;
    logic [15:0] ccr1_val;
    logic trig_hit;
    logic cap_hit;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire count_enable_bit = ctrl_r[`CTRL_CE_BIT];
    wire [2:0] mode_raw = ctrl_r[`CTRL_MODE_LSB +: 3];
    wire mode_free = (mode_raw == MODE_FREE_RUN);
    wire mode_pwm = (mode_raw == MODE_PULSE_WIDTH);
    wire mode_trig = (mode_raw == MODE_EXT_TRIG);
    wire wr_opt = reg_wr && (reg_addr == `ADDR_OPTION);
    wire wr_edge = reg_wr && (reg_addr == `ADDR_EDGE_SEL);
    wire wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
    wire wr_ccr0 = reg_wr && (reg_addr == `ADDR_CCR0);
    wire wr_ccr1 = reg_wr && (reg_addr == `ADDR_CCR1);
    wire wr_ists = reg_wr && (reg_addr == `ADDR_IRQ_STATUS);
    wire wr_imask = reg_wr && (reg_addr == `ADDR_IRQ_MASK);
    wire wr_bclr = reg_wr && (reg_addr == `ADDR_BIT_CLR);
    // capture select only counts in free-running mode
    wire cap0_mode = ccs0_r && mode_free;
    wire cap1_mode = ccs1_r && mode_free;
    wire wrap = count_enable_bit && (count_r == `CNT_TOP);
    wire ovf_event = wrap && (mode_free || mode_pwm);
    // byte write with bit 0 low, or bit-clear write addressing bit 0
    wire sw_clear = (wr_opt && !reg_wdata[`OPT_OVF_BIT]) ||
                    (wr_bclr && reg_wdata[`OPT_OVF_BIT]);
    wire cc0_match = count_enable_bit && (count_r == ccr0_val);
    wire cc1_match = count_enable_bit && (count_r == ccr1_val);
    wire [7:0] opt_read = {2'b00, ccs1_r, ccs0_r, 3'b000, overflow_flag_r};

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    edge_detect u_trig
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(ext_trigger_pin),
        .edge_sel(edge_sel_t'(edge_sel_r)),
        .edge_hit(trig_hit)
    );

    edge_detect u_cap
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(capture_pin),
        .edge_sel(EDGE_RISE),
        .edge_hit(cap_hit)
    );

    capcomp_reg u_ccr0
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(wr_ccr0),
        .wr_data(reg_wdata),
        .capture_mode(cap0_mode),
        .count_en(count_enable_bit),
        .capture_now(cap_hit),
        .count_val(count_r),
        .value(ccr0_val)
    );

    capcomp_reg u_ccr1
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(wr_ccr1),
        .wr_data(reg_wdata),
        .capture_mode(cap1_mode),
        .count_en(count_enable_bit),
        .capture_now(cap_hit),
        .count_val(count_r),
        .value(ccr1_val)
    );

    // ------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------
    // reads never touch the flag; option writes of 1 are dropped; set beats clear
    assign overflow_flag_nxt = !count_enable_bit ? 1'b0 :
                               ovf_event ? 1'b1 :
                               sw_clear ? 1'b0 :
                               overflow_flag_r;

    // ------------------------------------------------------------
    // counter and pulse output
    // ------------------------------------------------------------
    // in trigger mode the period is ccr0 + 1 counts: wrap after ccr0
    always_comb
    begin
        count_nxt = count_r;
        pstate_nxt = pstate_r;
        if (!count_enable_bit)
        begin
            count_nxt = `CNT_ZERO;
            pstate_nxt = PULSE_IDLE;
        end
        else if (mode_trig)
        begin
            case (pstate_r)
                PULSE_IDLE:
                begin
                    if (trig_hit)
                    begin
                        count_nxt = `CNT_ZERO;
                        pstate_nxt = PULSE_RUN;
                    end
                end
                PULSE_RUN:
                begin
                    if (trig_hit || count_r == ccr0_val)
                        count_nxt = `CNT_ZERO;
                    else
                        count_nxt = count_r + 16'h0001;
                end
                default:
                    pstate_nxt = PULSE_IDLE;
            endcase
        end
        else if (mode_pwm && cap_hit)
            count_nxt = `CNT_ZERO;
        else
            count_nxt = count_r + 16'h0001;
    end

    // active while count is below ccr1: ccr1 counts wide
    wire pulse_nxt = (pstate_nxt == PULSE_RUN) && mode_trig &&
                     (count_nxt < ccr1_val);

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [2:0] irq_events = {cc1_match, cc0_match, ovf_event};
    // set wins over write-one-to-clear
    assign irq_status_nxt = irq_events |
                            (irq_status_r & ~(wr_ists ? reg_wdata[2:0] : 3'b000));

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] rd_mux = (reg_addr == `ADDR_OPTION) ? {8'h00, opt_read} :
                         (reg_addr == `ADDR_EDGE_SEL) ? {14'h0000, edge_sel_r} :
                         (reg_addr == `ADDR_COUNT) ? count_r :
                         (reg_addr == `ADDR_CTRL) ? {8'h00, ctrl_r} :
                         (reg_addr == `ADDR_CCR0) ? ccr0_val :
                         (reg_addr == `ADDR_CCR1) ? ccr1_val :
                         (reg_addr == `ADDR_IRQ_STATUS) ? {13'h0000, irq_status_r} :
                         (reg_addr == `ADDR_IRQ_MASK) ? {13'h0000, irq_mask_r} :
                         16'h0000;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // plain storage: no hardware path ever writes these
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r <= `CTRL_RESET;
            edge_sel_r <= 2'b00;
            irq_mask_r <= 3'b000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata[7:0];
            if (wr_edge)
                edge_sel_r <= reg_wdata[`EDGE_LSB +: 2];
            if (wr_imask)
                irq_mask_r <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // option register
    // ------------------------------------------------------------
    // select bits take any write; the flag only follows its next value
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ccs0_r <= 1'b0;
            ccs1_r <= 1'b0;
            overflow_flag_r <= 1'b0;
        end
        else
        begin
            if (wr_opt)
            begin
                ccs0_r <= reg_wdata[`OPT_CCS0_BIT];
                ccs1_r <= reg_wdata[`OPT_CCS1_BIT];
            end
            overflow_flag_r <= overflow_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // count and pulse state
    // ------------------------------------------------------------
    // counter keeps its value across mode changes; ce=0, a trigger hit or a pulse-width capture restarts it
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r <= `CNT_ZERO;
            pstate_r <= PULSE_IDLE;
            pulse_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            pstate_r <= pstate_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt state
    // ------------------------------------------------------------
    // overflow pulse lines up with the flag setting edge
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ovf_irq_r <= 1'b0;
            irq_status_r <= 3'b000;
        end
        else
        begin
            ovf_irq_r <= ovf_event;
            irq_status_r <= irq_status_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // zero outside the answer cycle so the bus can be or-combined
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= 16'h0000;
        else
            rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end

    assign reg_rdata = rdata_r;
    assign pulse_out = pulse_r;
    assign overflow_irq = ovf_irq_r;
    assign irq = |(irq_status_r & irq_mask_r);
endmodule // timer_option_unit

// *** verification/timer_option_unit_properties.sv ***
`timescale 1ns/1ps
`include "timer_opt_params.svh"
module timer_option_unit_properties
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // pins and interrupts
    input wire logic ext_trigger_pin,
    input wire logic capture_pin,
    input wire logic pulse_out,
    input wire logic overflow_irq,
    input wire logic irq
);
// ----------------------------------------
// shadows of the control and mask writes
// ----------------------------------------
logic [7:0] ctrl_r;
logic [7:0] mask_r;
wire rd_opt = reg_rd && reg_addr == `ADDR_OPTION;
wire rd_cnt = reg_rd && reg_addr == `ADDR_COUNT;
wire free_run = ctrl_r == 8'h85;
always_ff @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        ctrl_r <= 8'h00;
        mask_r <= 8'h00;
    end
    else if (reg_wr && reg_addr == `ADDR_CTRL)
        ctrl_r <= reg_wdata[7:0];
    else if (reg_wr && reg_addr == `ADDR_IRQ_MASK)
        mask_r <= reg_wdata[7:0];
end
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
opt_reserved_a: assert property (rd_opt |=> reg_rdata[15:6] == 10'h0 && reg_rdata[3:1] == 3'h0)
    else $error("option reserved bits set");
ovf_pulse_a: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow pulse too long");
ovf_mode_a: assert property (overflow_irq |-> $past(ctrl_r[7]) && ($past(ctrl_r[2:0]) == 3'h5 || $past(ctrl_r[2:0]) == 3'h6))
    else $error("overflow in wrong mode");
ovf_ce_clr_a: assert property (rd_opt && !ctrl_r[7] && !$past(ctrl_r[7]) |=> !reg_rdata[0])
    else $error("flag set while stopped");
cnt_live_a: assert property (free_run && rd_cnt ##2 rd_cnt |=> reg_rdata == $past(reg_rdata, 2) + 16'h0002)
    else $error("count not live");
irq_mask_a: assert property (mask_r == 8'h00 |-> !irq)
    else $error("irq while fully masked");
endmodule // timer_option_unit_properties

// *** verification/timer_option_unit_tb.sv ***
`timescale 1ns/1ps
`include "timer_opt_params.svh"
module timer_option_unit_tb;
import timer_opt_pkg::*;
logic sys_clk = 1'b0;
logic rst_b = 1'b0;
logic [7:0] reg_addr = 8'h00;
logic [15:0] reg_wdata = 16'h0000;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [15:0] reg_rdata;
logic ext_trigger_pin = 1'b0;
logic capture_pin = 1'b0;
logic pulse_out;
logic overflow_irq;
logic irq;
int n_errors = 0;
int samples_checked = 0;
int cycles = 0;
int hi;
int lo;
logic [15:0] d;
logic [15:0] e;
logic [7:0] a;

timer_option_unit dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger_pin(ext_trigger_pin), .capture_pin(capture_pin), .pulse_out(pulse_out),
    .overflow_irq(overflow_irq), .irq(irq));

always #10 sys_clk = ~sys_clk;
// ----------------------------------------
// bus tasks and checks
// ----------------------------------------
task results;
    if (n_errors == 0 && samples_checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
        n_errors++;
        $display("BAD %s exp %h seen %h", w, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] ad, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
endtask
task automatic rd(input logic [7:0] ad, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
endtask
task automatic rc(input string w, input logic [7:0] ad, input logic [15:0] exp);
    logic [15:0] v;
    rd(ad, v);
    chk(w, v, exp);
endtask
task automatic ci(input logic exp);
    #1;
    chk("irq", {15'h0, irq}, {15'h0, exp});
endtask
// cycles until pulse_out reaches lvl, sampled just after each edge
task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (pulse_out !== lvl && n < 100)
    begin
        @(posedge sys_clk);
        #1;
        n++;
    end
endtask
always @(posedge sys_clk)
begin
    cycles++;
    if (cycles == 90000)
    begin
        n_errors++;
        results;
    end
end
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rc("option", `ADDR_OPTION, 16'h0000);
    rc("edge", `ADDR_EDGE_SEL, 16'h0000);
    wr(8'h40, 16'h00ff);
    rc("unmapped", 8'h40, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
        wr(`ADDR_EDGE_SEL, 16'(i));
        rc("edge", `ADDR_EDGE_SEL, 16'(i));
    end
    for (int i = 0; i < 2; i++)
    begin
        a = `ADDR_CCR0 + 8'(4 * i);
        wr(`ADDR_CTRL, 16'h0005);
        wr(`ADDR_OPTION, 16'h0010 << i);
        wr(a, 16'h1234);
        rc("capture", a, 16'h0000);
        wr(`ADDR_OPTION, 16'h0000);
        wr(a, 16'h1234);
        rc("compare", a, 16'h1234);
        wr(`ADDR_CTRL, 16'h0001);
        wr(`ADDR_OPTION, 16'h0030);
        wr(a, 16'h0abc);
        rc("select", a, 16'h0abc);
    end
    wr(`ADDR_OPTION, 16'h0000);
    wr(`ADDR_CCR0, 16'h0009);
    wr(`ADDR_CCR1, 16'h0003);
    wr(`ADDR_CTRL, 16'h0081);
    ext_trigger_pin <= 1'b1;
    wait_lvl(1'b1, hi);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    chk("width", 16'(hi), 16'h0003);
    chk("period", 16'(hi + lo), 16'h000a);
    wr(`ADDR_CTRL, 16'h0085);
    wr(`ADDR_IRQ_MASK, 16'h0001);
    rd(`ADDR_COUNT, d);
    rd(`ADDR_COUNT, e);
    chk("count", e, d + 16'h0002);
    // a full wrap of the counter, bounded by the cycle ceiling
    while (overflow_irq !== 1'b1)
    begin
        @(posedge sys_clk);
        #1;
    end
    chk("irq", {15'h0, irq}, 16'h0001);
    rc("flag", `ADDR_OPTION, 16'h0001);
    rc("flag", `ADDR_OPTION, 16'h0001);
    chk("ovf_irq", {15'h0, overflow_irq}, 16'h0000);
    wr(`ADDR_OPTION, 16'h0001);
    rc("flag", `ADDR_OPTION, 16'h0001);
    wr(`ADDR_OPTION, 16'h0000);
    rc("flag", `ADDR_OPTION, 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0000);
    ci(1'b0);
    wr(`ADDR_IRQ_MASK, 16'h0001);
    ci(1'b1);
    wr(`ADDR_IRQ_STATUS, 16'h0001);
    ci(1'b0);
    wr(`ADDR_EDGE_SEL, 16'h0000);
    rc("edge", `ADDR_EDGE_SEL, 16'h0000);
    results;
end
endmodule // timer_option_unit_tb

bind timer_option_unit timer_option_unit_properties chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin), .capture_pin(capture_pin),
    .pulse_out(pulse_out), .overflow_irq(overflow_irq), .irq(irq));
